/* File: rtl/adc_readout_pkg.sv */
// constants shared by the converter readout logic and its testbench
package adc_readout_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;
	// conversion length, arbitrary but long enough to hold an internal readout
	localparam int CONV_TIME_NS = 8000;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
	// internal_readout_delay: wait from conversion start to first bit clock
	localparam int INTERNAL_READOUT_DELAY_NS = 200;
	localparam int INTERNAL_READOUT_DELAY_CYCLES =
		(INTERNAL_READOUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] DELAY_LAST = 4'(INTERNAL_READOUT_DELAY_CYCLES - 1);

	// ************************************************************
	// word layout and bit clock phases
	// ************************************************************
	localparam int WORD_WIDTH = 16;
	localparam logic [4:0] WORD_BITS = 5'h10;
	localparam logic [15:0] MSB_MASK = 16'h8000;
	localparam logic [1:0] PHASE_LOAD = 2'h0;
	localparam logic [1:0] PHASE_RISE = 2'h1;
	localparam logic [1:0] PHASE_FALL = 2'h3;
	localparam int SYNC_BITS = 7;

	// ************************************************************
	// state machines
	// ************************************************************
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_CONV = 3'b010,
		C_DONE = 3'b100
	} conv_state_t;

	typedef enum logic [3:0] {
		R_IDLE = 4'b0001,
		R_WAIT = 4'b0010,
		R_INT = 4'b0100,
		R_EXT = 4'b1000
	} read_state_t;

endpackage : adc_readout_pkg

/* File: rtl/word_buffer.sv */
// two-entry valid/ready buffer between conversion core and result storage
`timescale 1ns/10ps
`default_nettype none

module word_buffer #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// filling side
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// draining side
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [PW:0] count_r;
	wire do_push;
	wire do_pop;

	// handshakes; full and empty come straight from the count
	assign in_ready_out = (count_r != (PW+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out = mem[rd_ptr_r];
	assign do_push = in_valid_in & in_ready_out;
	assign do_pop = out_valid_out & out_ready_in;

	// storage array, no reset needed on data
	always_ff @(posedge clock_in) begin
		if (do_push) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

endmodule : word_buffer

`default_nettype wire

/* File: rtl/adc_readout.sv */
// conversion start, busy framing and serial result readout of the converter
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - conversion starts when the later of chip select and read/convert falls
// - busy low at start, high once result sits in storage
// - readout always gives the most recently completed result
// - output format chosen by the format select level
// - format select high gives straight binary, low gives two's complement
// - result words go out most significant bit first
// - first conversion after reset is flagged as not valid
// - clock select low drives the bit clock pin, high makes it an input
// - internal mode: 16 bit clock pulses after a delay at conversion start
// - internal mode: bit clock idles low, bit valid at rise and fall
// - after the last bit, data shows cascade input captured at start
// - internal mode sends a word every conversion regardless of controls
// - external mode: controls open the read, bits valid fall then rise
// - chip select tied low: read/convert alone converts and reads
// - clock seen outside read gives a frame marker on first rise
// - no clock outside read: no marker, first rise shifts out the MSB
// - external mode: cascade input passes through after the word, first the level captured at read entry
// - power down refuses conversions, keeps the output shift register
// - external read entered on read/convert rise with select low, or select fall
module adc_readout
	import adc_readout_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic resetn_in,
	// control pins
	input wire logic chip_select_n_in,
	input wire logic read_convert_in,
	input wire logic clock_source_ext_in,
	input wire logic output_format_select_in,
	input wire logic power_down_in,
	input wire logic cascade_in,
	// result from the conversion core
	input wire logic [15:0] core_result_in,
	// bit clock pin, split
	input wire logic serial_bit_clock_in,
	output logic serial_bit_clock_out,
	output logic serial_bit_clock_oe_out,
	// serial outputs and status
	output logic serial_data_out,
	output logic frame_sync_out,
	output logic busy_out,
	output logic result_valid_out
);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [SYNC_BITS-1:0] sync1_r;
	logic [SYNC_BITS-1:0] sync2_r;
	logic bclk_d_r;
	wire [SYNC_BITS-1:0] pins_raw;
	wire cs_n_s;
	wire rc_s;
	wire ext_s;
	wire fmt_s;
	wire power_down_in_s;
	wire tag_s;
	wire bclk_s;
	wire bclk_rise;

	assign pins_raw = {chip_select_n_in, read_convert_in, clock_source_ext_in,
		output_format_select_in, power_down_in, cascade_in, serial_bit_clock_in};

	// two flops per pin; first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_BITS; gi++) begin : g_sync
			always_ff @(posedge clock_in or negedge resetn_in) begin
				if (!resetn_in) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= pins_raw[gi];
					sync2_r[gi] <= sync1_r[gi];
				end
			end
		end
	endgenerate

	assign {cs_n_s, rc_s, ext_s, fmt_s, power_down_in_s, tag_s, bclk_s} = sync2_r;

	// edge finder works on the second stage only
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bclk_d_r <= 1'b0;
		end else begin
			bclk_d_r <= bclk_s;
		end
	end
	assign bclk_rise = bclk_s & ~bclk_d_r;

	// ************************************************************
	// conversion control
	// ************************************************************
	conv_state_t c_state_r;
	conv_state_t c_state_nxt;
	logic [7:0] conv_cnt_r;
	logic conv_req_d_r;
	logic busy_r;
	wire conv_req;
	wire start_conv;
	wire conv_last;
	wire buf_in_ready;
	wire buf_out_valid;
	wire buf_out_ready;
	wire [15:0] buf_out_data;
	wire pop;
	wire read_busy;
	read_state_t r_state_r;
	read_state_t r_state_nxt;

	// both controls low; edge of the pair is the later falling pin
	// start on second fall
	assign conv_req = ~cs_n_s & ~rc_s;
	assign start_conv = (c_state_r == C_IDLE) & conv_req & ~conv_req_d_r & ~power_down_in_s & busy_r;
	assign conv_last = (conv_cnt_r == CONV_LAST);

	// next state; a full buffer holds the core in C_DONE
	always_comb begin
		case (c_state_r)
			C_IDLE: c_state_nxt = start_conv ? C_CONV : C_IDLE;
			C_CONV: c_state_nxt = conv_last ? C_DONE : C_CONV;
			C_DONE: c_state_nxt = buf_in_ready ? C_IDLE : C_DONE;
			default: c_state_nxt = C_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			c_state_r <= C_IDLE;
			conv_cnt_r <= '0;
			conv_req_d_r <= 1'b1; // sync stages reset low; avoids a false start at release
		end else begin
			c_state_r <= c_state_nxt;
			conv_cnt_r <= (c_state_r == C_CONV) ? conv_cnt_r + 8'h01 : 8'h00;
			conv_req_d_r <= conv_req;
		end
	end

	// storage only updates between reads so a word never changes mid-shift
	assign read_busy = (r_state_r != R_IDLE);
	assign buf_out_ready = ~read_busy;
	assign pop = buf_out_valid & buf_out_ready;

	word_buffer #(
		.WIDTH(WORD_WIDTH),
		.DEPTH(2)
	) u_buf (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.in_valid_in(c_state_r == C_DONE),
		.in_data_in(core_result_in),
		.in_ready_out(buf_in_ready),
		.out_valid_out(buf_out_valid),
		.out_data_out(buf_out_data),
		.out_ready_in(buf_out_ready)
	);

	// ************************************************************
	// result storage and busy
	// ************************************************************
	logic [15:0] store_r;
	logic [1:0] loads_r;
	logic result_valid_r;

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			busy_r <= 1'b1;
			store_r <= '0;
			loads_r <= '0;
			result_valid_r <= 1'b0;
		end else begin
			if (start_conv) begin
				busy_r <= 1'b0;
			end else if (pop) begin
				busy_r <= 1'b1;
			end
			if (pop) begin
				store_r <= buf_out_data;
				loads_r <= (loads_r == 2'h2) ? loads_r : loads_r + 2'h1;
				result_valid_r <= (loads_r != 2'h0);
			end
		end
	end

	// ************************************************************
	// serial readout
	// ************************************************************
	logic [16:0] shift_r;
	logic [4:0] bitcnt_r;
	logic [1:0] phase_r;
	logic [3:0] dly_r;
	logic tag_cap_r;
	logic saw_clk_r;
	logic sync_pend_r;
	logic rd_cond_d_r;
	logic data_r;
	logic fsync_r;
	logic bclk_out_r;
	logic bclk_oe_r;
	wire rd_cond;
	wire ext_enter;
	wire int_enter;
	wire [15:0] word_fmt;
	wire int_load;
	wire int_done;
	wire ext_shift;

	// select tied low leaves read/convert in charge
	assign rd_cond = ~cs_n_s & rc_s;
	assign ext_enter = (r_state_r == R_IDLE) & ext_s & rd_cond & ~rd_cond_d_r;
	assign int_enter = (r_state_r == R_IDLE) & ~ext_s & start_conv;
	assign word_fmt = fmt_s ? store_r : (store_r ^ MSB_MASK);
	assign int_load = (r_state_r == R_INT) & (phase_r == PHASE_LOAD);
	assign int_done = int_load & (bitcnt_r == WORD_BITS);
	assign ext_shift = (r_state_r == R_EXT) & bclk_rise & ~sync_pend_r;

	always_comb begin
		case (r_state_r)
			R_IDLE: r_state_nxt = ext_enter ? R_EXT : (int_enter ? R_WAIT : R_IDLE);
			R_WAIT: r_state_nxt = (dly_r == DELAY_LAST) ? R_INT : R_WAIT;
			R_INT: r_state_nxt = int_done ? R_IDLE : R_INT;
			R_EXT: r_state_nxt = (rd_cond & ext_s) ? R_EXT : R_IDLE;
			default: r_state_nxt = R_IDLE;
		endcase
	end

	// state and counters of the readout
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			r_state_r <= R_IDLE;
			rd_cond_d_r <= 1'b0;
			dly_r <= '0;
			phase_r <= '0;
			bitcnt_r <= '0;
		end else begin
			r_state_r <= r_state_nxt;
			rd_cond_d_r <= rd_cond;
			dly_r <= (r_state_r == R_WAIT) ? dly_r + 4'h1 : 4'h0;
			phase_r <= (r_state_r == R_INT) ? phase_r + 2'h1 : 2'h0;
			if (r_state_r != R_INT) begin
				bitcnt_r <= '0;
			end else if (phase_r == PHASE_FALL) begin
				bitcnt_r <= bitcnt_r + 5'h01;
			end
		end
	end

	// shift register: word then cascade bits fed in behind it
	// msb first
	// captured cascade level trails the word
	// cascade bits follow in external mode
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			shift_r <= '0;
			tag_cap_r <= 1'b0;
			data_r <= 1'b0;
		end else if (ext_enter | int_enter) begin
			shift_r <= {word_fmt, tag_s};
			tag_cap_r <= tag_s;
		end else if (int_load) begin
			data_r <= shift_r[16];
			shift_r <= {shift_r[15:0], tag_cap_r};
		end else if (ext_shift) begin
			data_r <= shift_r[16];
			shift_r <= {shift_r[15:0], tag_s};
		end
	end

	// frame marker: any rise seen outside an external read arms it
	// marker on first rise
	// no marker when clock was idle
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			saw_clk_r <= 1'b0;
			sync_pend_r <= 1'b0;
			fsync_r <= 1'b0;
		end else begin
			if (ext_enter) begin
				saw_clk_r <= 1'b0;
				sync_pend_r <= saw_clk_r | bclk_rise;
			end else if (bclk_rise & (r_state_r != R_EXT)) begin
				saw_clk_r <= 1'b1;
			end else if (bclk_rise & sync_pend_r) begin
				sync_pend_r <= 1'b0;
			end
			if (r_state_r != R_EXT) begin
				fsync_r <= 1'b0;
			end else if (bclk_rise) begin
				fsync_r <= sync_pend_r;
			end
		end
	end

	// bit clock: idles low, high on phases 1-2 so the bit spans rise and fall
	// sixteen pulses
	// external mode only listens to the pin
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bclk_out_r <= 1'b0;
			bclk_oe_r <= 1'b0;
		end else begin
			bclk_out_r <= (r_state_r == R_INT) & (bitcnt_r != WORD_BITS) &
				((phase_r == PHASE_RISE) | (phase_r == 2'h2));
			bclk_oe_r <= ~ext_s;
		end
	end

	// outputs straight from flops
	assign serial_bit_clock_out = bclk_out_r;
	assign serial_bit_clock_oe_out = bclk_oe_r;
	assign serial_data_out = data_r;
	assign frame_sync_out = fsync_r;
	assign busy_out = busy_r;
	assign result_valid_out = result_valid_r;

	// ************************************************************
	// checks
	// ************************************************************
	logic [4:0] pulse_cnt_r;

	// counts rising edges of the driven bit clock during one internal read
	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pulse_cnt_r <= '0;
		end else if (int_enter) begin
			pulse_cnt_r <= '0;
		end else if (bclk_out_r & (r_state_r == R_INT) & (phase_r == 2'h2)) begin
			pulse_cnt_r <= pulse_cnt_r + 5'h01;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	chk_start_pair: assert property ($fell(busy_r) |-> $past(conv_req) && !$past(conv_req_d_r))
		else $error("conversion started without both controls falling");
	chk_busy_rise: assert property ($rose(busy_out) |-> $past(pop) && store_r == $past(buf_out_data))
		else $error("busy rose without a result loaded");
	chk_busy_fall: assert property (start_conv |-> ##2 !busy_out)
		else $error("busy not low after conversion start");
	chk_format_load: assert property ((ext_enter || int_enter) |=>
		shift_r[16:1] == ($past(store_r) ^ ($past(fmt_s) ? 16'h0000 : MSB_MASK)))
		else $error("loaded word has wrong format");
	chk_int_pulses: assert property (int_done |-> pulse_cnt_r == WORD_BITS)
		else $error("internal read did not give sixteen pulses");
	chk_int_idle_low: assert property ((r_state_r == R_IDLE) |=> !serial_bit_clock_out)
		else $error("bit clock not low while idle");
	chk_tag_trail: assert property (int_done |=> serial_data_out == tag_cap_r)
		else $error("data does not show captured cascade level after word");
	chk_power_down_in_refuse: assert property (power_down_in_s && c_state_r == C_IDLE |=> c_state_r == C_IDLE)
		else $error("conversion started in power down");
	chk_pin_dir: assert property (ext_s |=> !serial_bit_clock_oe_out)
		else $error("bit clock driven in external mode");
	chk_sync_edge: assert property ($rose(frame_sync_out) |-> $past(bclk_rise) && $past(sync_pend_r))
		else $error("frame marker without armed first rise");

	cov_int_read: cover property (int_done);
	cov_ext_sync: cover property ((r_state_r == R_EXT) && frame_sync_out);
	cov_ext_nosync: cover property (ext_enter && !saw_clk_r && !bclk_rise);
	cov_power_down_in_hold: cover property (power_down_in_s && conv_req && !conv_req_d_r);

endmodule : adc_readout

`default_nettype wire

/* File: tb/host_port_model.sv */
// host serial port model that clocks and captures converter result words
`timescale 1ns/10ps
`default_nettype none

module host_port_model (
	// pin side
	input wire logic bit_clock_in,
	input wire logic pin_driven_in,
	input wire logic data_in,
	input wire logic marker_in,
	// host clock driver
	output logic host_clock_out
);
	logic [15:0] int_word;
	int int_count;

	// ************************************************************
	// internal bit clock capture
	// ************************************************************
	// sample at device rise
	always @(posedge bit_clock_in) begin
		if (pin_driven_in) begin
			int_word = {int_word[14:0], data_in};
			int_count++;
		end
	end

	// ************************************************************
	// external bit clock frames
	// ************************************************************
	// 800 ns period, clock held low outside frames
	// sample at each falling edge, before lowering the clock
	task automatic clock_frame(input int pulses, output logic [17:0] bits,
		output logic [17:0] marks);
		bits = '0;
		marks = '0;
		for (int i = 0; i < pulses; i++) begin
			#400 host_clock_out = 1'b1;
			#400 bits = {bits[16:0], data_in};
			marks = {marks[16:0], marker_in};
			host_clock_out = 1'b0;
		end
	endtask : clock_frame

	// clock stands still low until a frame is asked for
	initial host_clock_out = 1'b0;
endmodule : host_port_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the converter readout with a host port model
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	import adc_readout_pkg::*;

	logic clock_in, resetn_in, cs_n, rc, ext, fmt_sel, pd, tag;
	logic [15:0] core_val, v, prev;
	logic bclk_out, bclk_oe, sdata, fsync, busy, rvalid, host_clk;
	wire logic bclk_pin;
	logic [17:0] got, marks;
	integer seed = 32'hae31;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;

	// pin level follows whoever enables its driver
	assign bclk_pin = bclk_oe ? bclk_out : host_clk;

	adc_readout dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
		.chip_select_n_in(cs_n), .read_convert_in(rc), .clock_source_ext_in(ext),
		.output_format_select_in(fmt_sel), .power_down_in(pd), .cascade_in(tag),
		.core_result_in(core_val), .serial_bit_clock_in(bclk_pin),
		.serial_bit_clock_out(bclk_out), .serial_bit_clock_oe_out(bclk_oe),
		.serial_data_out(sdata), .frame_sync_out(fsync), .busy_out(busy),
		.result_valid_out(rvalid));

	host_port_model host_u (.bit_clock_in(bclk_pin), .pin_driven_in(bclk_oe),
		.data_in(sdata), .marker_in(fsync), .host_clock_out(host_clk));

	// ************************************************************
	// clock, hang guard and helpers
	// ************************************************************
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	// whole run needs about 1000 cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			finish_test();
		end
	end

	function automatic logic [15:0] fmt(input logic [15:0] raw, input logic sb);
		return sb ? raw : raw ^ MSB_MASK;
	endfunction : fmt

	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clock_in);
	endtask : tick

	task automatic wait_busy(input logic lvl, input int limit);
		int i;
		i = 0;
		while (busy !== lvl && i < limit) begin
			tick(1);
			i++;
		end
		chk(busy, lvl);
	endtask : wait_busy

	// second falling control starts the conversion
	task automatic convert(input logic [15:0] val, input logic cs_last);
		core_val = val;
		if (cs_last)
			rc = 1'b0;
		else
			cs_n = 1'b0;
		tick(3);
		if (cs_last)
			cs_n = 1'b0;
		else
			rc = 1'b0;
		wait_busy(1'b0, 10);
	endtask : convert

	// deselect first so raising read/convert opens no read
	task automatic idle_ctrl();
		cs_n = 1'b1;
		tick(1);
		rc = 1'b1;
		tick(3);
	endtask : idle_ctrl

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		resetn_in = 1'b0;
		cs_n = 1'b1;
		rc = 1'b1;
		ext = 1'b0;
		fmt_sel = 1'b1;
		pd = 1'b0;
		tag = 1'b0;
		core_val = 16'h0000;
		prev = 16'h0000;
		tick(20);
		resetn_in = 1'b1;
		chk(rvalid, 1'b0);
		tick(5);
		chk(bclk_oe, 1'b1);
		// internal clock: both start orders, both formats
		for (int k = 0; k < 4; k++) begin
			v = 16'($random(seed));
			fmt_sel = k[0];
			tag = v[0];
			host_u.int_count = 0;
			convert(v, k[1]);
			tag = ~v[0];
			wait_busy(1'b1, 200);
			chk(rvalid, k > 0);
			chk(host_u.int_count, 16);
			if (k > 0) begin
				chk(host_u.int_word, fmt(prev, k[0]));
			end
			chk(sdata, v[0]);
			chk(bclk_out, 1'b0);
			idle_ctrl();
			prev = v;
		end
		$display("test internal readout done");
		// power down refuses a start
		pd = 1'b1;
		tick(3);
		rc = 1'b0;
		cs_n = 1'b0;
		tick(10);
		chk(busy, 1'b1);
		idle_ctrl();
		pd = 1'b0;
		$display("test power down done");
		// external clock, stray rise arms the marker; cascade held low
		ext = 1'b1;
		fmt_sel = 1'b1;
		tag = 1'b0;
		tick(5);
		chk(bclk_oe, 1'b0);
		host_u.clock_frame(1, got, marks);
		tick(2);
		cs_n = 1'b0;
		tick(5);
		host_u.clock_frame(18, got, marks);
		chk(marks, 18'h2_0000);
		chk(got[16:0], {fmt(prev, 1'b1), 1'b0});
		idle_ctrl();
		// no marker, cascade bits after the word
		fmt_sel = 1'b0;
		tag = 1'b1;
		tick(3);
		cs_n = 1'b0;
		tick(10);
		tag = 1'b0;
		tick(3);
		host_u.clock_frame(18, got, marks);
		chk(marks, 18'h0_0000);
		chk(got, {fmt(prev, 1'b0), 2'b10});
		idle_ctrl();
		$display("test external readout done");
		// read during conversion, stalled past the end of conversion
		v = 16'($random(seed));
		fmt_sel = 1'b1;
		convert(v, 1'b1);
		rc = 1'b1;
		tick(4);
		host_u.clock_frame(3, got, marks);
		chk(got[2:0], 3'(fmt(prev, 1'b1) >> 13));
		tick(CONV_CYCLES);
		chk(busy, 1'b0);
		idle_ctrl();
		wait_busy(1'b1, 20);
		cs_n = 1'b0;
		tick(5);
		host_u.clock_frame(17, got, marks);
		chk(got[16:0], {fmt(v, 1'b1), 1'b0});
		idle_ctrl();
		$display("test stalled read done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
